// *** rtl/aopt_ahb_front.sv ***
// AHB-Lite slave front end: address phase capture, write strobe and registered read data.
`timescale 1ns/1ps
`default_nettype none
module aopt_ahb_front
  import aopt_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic              hready,
  input  wire logic [31:0]       rd_value,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   wr_strobe,
  output logic [ADDR_W-1:0]      reg_addr
);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr_pend;
    logic              rd_wait;
    logic              readyout;
    logic [31:0]       rdata;
  } aopt_front_s;

  aopt_front_s st;
  aopt_front_s next_st;

  // Reads take one wait state so that read data always comes from a flip-flop
  // and already reflects a write finished in the preceding data phase.
  always_comb begin
    next_st         = st;
    next_st.wr_pend = 1'b0;
    if (st.rd_wait) begin
      next_st.rdata    = rd_value;
      next_st.readyout = 1'b1;
      next_st.rd_wait  = 1'b0;
    end
    if (hsel && htrans[1] && hready) begin
      next_st.addr = {haddr[ADDR_W-1:2], 2'b00};
      if (hwrite) begin
        next_st.wr_pend = 1'b1;
      end else begin
        next_st.rd_wait  = 1'b1;
        next_st.readyout = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{addr: '0, wr_pend: 1'b0, rd_wait: 1'b0, readyout: 1'b1, rdata: 32'h0000_0000};
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.readyout;
  assign hrdata    = st.rdata;
  assign wr_strobe = st.wr_pend;
  assign reg_addr  = st.addr;

endmodule : aopt_ahb_front
`default_nettype wire

// *** rtl/aopt_pkg.sv ***
// Register map, field positions and reset values of the always-on counter and periodic timer.
package aopt_pkg;

  localparam logic [11:0] OFS_POWER_SETTING_LOCK      = 12'h594;
  localparam logic [11:0] OFS_FREE_COUNTER_VALUE      = 12'h700;
  localparam logic [11:0] OFS_FREE_COUNTER_ENABLE     = 12'h704;
  localparam logic [11:0] OFS_PERIODIC_TIMER_VALUE    = 12'h708;
  localparam logic [11:0] OFS_PERIODIC_TIMER_STATUS   = 12'h70C;
  localparam logic [11:0] OFS_PERIODIC_TIMER_CONTROL  = 12'h710;
  localparam logic [11:0] OFS_PERIODIC_TIMEOUT_CONFIG = 12'h714;
  localparam logic [11:0] OFS_EVENT_STATUS            = 12'h720;
  localparam logic [11:0] OFS_EVENT_MASK              = 12'h724;
  localparam logic [11:0] OFS_WAKE_MASK               = 12'h728;
  localparam logic [11:0] OFS_POWER_WAIT_CONFIG       = 12'h72C;

  localparam int ADDR_W = 12;

  localparam int BIT_WAKE_MASK_FREEZE  = 17;
  localparam int BIT_STROBE_WAIT_FREEZE = 16;
  localparam int BIT_FREE_COUNTER_RUN  = 0;
  localparam int BIT_PERIODIC_ALARM    = 0;
  localparam int BIT_PERIODIC_ALARM_CLEAR = 0;
  localparam int BIT_PERIODIC_RELOAD   = 1;
  localparam int BIT_EV_PERIODIC_ALARM = 0;
  localparam int BIT_EV_FREE_WRAP      = 1;
  localparam int EV_W                  = 2;

  localparam logic [31:0] RST_FREE_COUNTER_VALUE      = 32'h0000_0000;
  localparam logic        RST_FREE_COUNTER_RUN        = 1'h1;
  localparam logic [31:0] RST_PERIODIC_TIMER_VALUE    = 32'h0000_0000;
  localparam logic        RST_PERIODIC_ALARM_FLAG     = 1'h1;
  localparam logic [31:0] RST_PERIODIC_TIMEOUT_CONFIG = 32'h0000_0000;
  localparam logic [1:0]  RST_EVENT                   = 2'h0;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

endpackage : aopt_pkg

// *** rtl/aopt_timer.sv ***
// Always-on free-running counter and periodic down-counter with power setting locks.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Bit 17 sticky write-one lock freezes wake mask
// - Bit 16 sticky write-one lock freezes strobe wait
// - Free counter is 32-bit read-only, resets zero
// - Bit 0 enable gates free counter, resets one
// - Periodic counter value readable, 32-bit, resets zero
// - Status bit 0 set on wrap, resets one
// - No new alarm while status flag set
// - Control bit 1 reloads counter from timeout
// - Control bit 0 clears pending alarm flag
// - Zero timeout holds periodic counter disabled
// - Nonzero timeout loads counter, decrements each tick
// - At zero raise interrupt and reload timeout
module aopt_timer
  import aopt_pkg::*;
#(
  parameter int WAKE_W = 32,
  parameter int WAIT_W = 8
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   irq,
  output logic [WAKE_W-1:0]      wake_mask,
  output logic [WAIT_W-1:0]      voltage_strobe_delay
);

  generate
    if (WAKE_W < 1 || WAKE_W > 32) begin : g_bad_wake
      $error("WAKE_W must lie between 1 and 32");
    end
    if (WAIT_W < 1 || WAIT_W > 32) begin : g_bad_wait
      $error("WAIT_W must lie between 1 and 32");
    end
  endgenerate

  typedef struct packed {
    logic              wake_freeze;
    logic              strobe_wait_freeze;
    logic [31:0]       free_cnt;
    logic              free_counter_run;
    logic [31:0]       pt_cnt;
    logic              pt_running;
    logic              periodic_alarm_flag;
    logic              periodic_reload;
    logic              periodic_alarm_clear;
    logic [31:0]       timeout_cfg;
    logic [EV_W-1:0]   ev_status;
    logic [EV_W-1:0]   ev_mask;
    logic [WAKE_W-1:0] wake;
    logic [WAIT_W-1:0] power_wait_config;
    logic              irq;
  } aopt_state_s;

  aopt_state_s st;
  aopt_state_s next_st;

  logic              wr_strobe;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       rd_value;
  logic              pt_wrap;
  logic              alarm_event;
  logic              free_wrap;
  logic [EV_W-1:0]   ev_set;

  aopt_ahb_front u_front (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .rd_value  (rd_value),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .wr_strobe (wr_strobe),
    .reg_addr  (reg_addr)
  );

  // Every transfer is served as a word access; the size is not decoded and errors are never signalled.
  assign hresp = HRESP_OKAY;

  // Read multiplexer; unmapped offsets and reserved bits read as zero.
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (reg_addr)
      OFS_POWER_SETTING_LOCK: begin
        rd_value[BIT_WAKE_MASK_FREEZE]   = st.wake_freeze;
        rd_value[BIT_STROBE_WAIT_FREEZE] = st.strobe_wait_freeze;
      end
      OFS_FREE_COUNTER_VALUE: begin
        rd_value = st.free_cnt;
      end
      OFS_FREE_COUNTER_ENABLE: begin
        rd_value[BIT_FREE_COUNTER_RUN] = st.free_counter_run;
      end
      OFS_PERIODIC_TIMER_VALUE: begin
        rd_value = st.pt_cnt;
      end
      OFS_PERIODIC_TIMER_STATUS: begin
        rd_value[BIT_PERIODIC_ALARM] = st.periodic_alarm_flag;
      end
      OFS_PERIODIC_TIMER_CONTROL: begin
        rd_value[BIT_PERIODIC_RELOAD]      = st.periodic_reload;
        rd_value[BIT_PERIODIC_ALARM_CLEAR] = st.periodic_alarm_clear;
      end
      OFS_PERIODIC_TIMEOUT_CONFIG: begin
        rd_value = st.timeout_cfg;
      end
      OFS_EVENT_STATUS: begin
        rd_value[EV_W-1:0] = st.ev_status;
      end
      OFS_EVENT_MASK: begin
        rd_value[EV_W-1:0] = st.ev_mask;
      end
      OFS_WAKE_MASK: begin
        rd_value[WAKE_W-1:0] = st.wake;
      end
      OFS_POWER_WAIT_CONFIG: begin
        rd_value[WAIT_W-1:0] = st.power_wait_config;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // The counter wraps when a running count reaches zero. An alarm is only
  // indicated while the flag is clear, so a missed clear never stacks alarms.
  assign pt_wrap     = st.pt_running && (st.pt_cnt == 32'h0000_0000);
  assign alarm_event = pt_wrap && !st.periodic_alarm_flag;
  assign free_wrap   = st.free_counter_run && (st.free_cnt == 32'hFFFF_FFFF);

  always_comb begin
    ev_set                        = '0;
    ev_set[BIT_EV_PERIODIC_ALARM] = alarm_event;
    ev_set[BIT_EV_FREE_WRAP]      = free_wrap;
  end

  always_comb begin
    next_st = st;

    // Free-running up-counter.
    if (st.free_counter_run) begin
      next_st.free_cnt = st.free_cnt + 32'h0000_0001;
    end

    // Periodic down-counter.
    if (st.timeout_cfg == 32'h0000_0000) begin
      next_st.pt_cnt     = 32'h0000_0000;
      next_st.pt_running = 1'b0;
    end else if (st.periodic_reload) begin
      next_st.pt_cnt     = st.timeout_cfg;
      next_st.pt_running = 1'b1;
    end else if (st.pt_cnt == 32'h0000_0000) begin
      next_st.pt_cnt     = st.timeout_cfg;
      next_st.pt_running = 1'b1;
    end else begin
      next_st.pt_cnt = st.pt_cnt - 32'h0000_0001;
    end

    // Control actions last one cycle and then drop by themselves.
    next_st.periodic_reload      = 1'b0;
    next_st.periodic_alarm_clear = 1'b0;
    if (st.periodic_alarm_clear) begin
      next_st.periodic_alarm_flag               = 1'b0;
      next_st.ev_status[BIT_EV_PERIODIC_ALARM] = 1'b0;
    end

    // Register writes.
    if (wr_strobe) begin
      unique case (reg_addr)
        OFS_POWER_SETTING_LOCK: begin
          if (hwdata[BIT_WAKE_MASK_FREEZE]) begin
            next_st.wake_freeze = 1'b1;
          end
          if (hwdata[BIT_STROBE_WAIT_FREEZE]) begin
            next_st.strobe_wait_freeze = 1'b1;
          end
        end
        OFS_FREE_COUNTER_ENABLE: begin
          next_st.free_counter_run = hwdata[BIT_FREE_COUNTER_RUN];
        end
        OFS_PERIODIC_TIMER_CONTROL: begin
          if (hwdata[BIT_PERIODIC_RELOAD]) begin
            next_st.periodic_reload = 1'b1;
          end
          if (hwdata[BIT_PERIODIC_ALARM_CLEAR]) begin
            next_st.periodic_alarm_clear = 1'b1;
          end
        end
        OFS_PERIODIC_TIMEOUT_CONFIG: begin
          next_st.timeout_cfg = hwdata;
        end
        OFS_EVENT_STATUS: begin
          next_st.ev_status = next_st.ev_status & ~hwdata[EV_W-1:0];
        end
        OFS_EVENT_MASK: begin
          next_st.ev_mask = hwdata[EV_W-1:0];
        end
        OFS_WAKE_MASK: begin
          if (!st.wake_freeze) begin
            next_st.wake = hwdata[WAKE_W-1:0];
          end
        end
        OFS_POWER_WAIT_CONFIG: begin
          if (!st.strobe_wait_freeze) begin
            next_st.power_wait_config = hwdata[WAIT_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Hardware events win over any clear in the same cycle.
    if (alarm_event) begin
      next_st.periodic_alarm_flag = 1'b1;
    end
    next_st.ev_status = next_st.ev_status | ev_set;
    next_st.irq       = |(next_st.ev_status & next_st.ev_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{
        wake_freeze:          1'b0,
        strobe_wait_freeze:   1'b0,
        free_cnt:             RST_FREE_COUNTER_VALUE,
        free_counter_run:     RST_FREE_COUNTER_RUN,
        pt_cnt:               RST_PERIODIC_TIMER_VALUE,
        pt_running:           1'b0,
        periodic_alarm_flag:  RST_PERIODIC_ALARM_FLAG,
        periodic_reload:      1'b0,
        periodic_alarm_clear: 1'b0,
        timeout_cfg:          RST_PERIODIC_TIMEOUT_CONFIG,
        ev_status:            RST_EVENT,
        ev_mask:              RST_EVENT,
        wake:                 '0,
        power_wait_config:    '0,
        irq:                  1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  assign irq                  = st.irq;
  assign wake_mask            = st.wake;
  assign voltage_strobe_delay = st.power_wait_config;

endmodule : aopt_timer
`default_nettype wire

// *** verif/aopt_sva.sv ***
// Port-level assertions for the always-on counter and periodic timer.
`timescale 1ns/1ps
`default_nettype none
module aopt_sva
  import aopt_pkg::*;
#(
  parameter int WAKE_W = 32,
  parameter int WAIT_W = 8
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic              hready,
  input wire logic [31:0]       hwdata,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              irq,
  input wire logic [WAKE_W-1:0] wake_mask,
  input wire logic [WAIT_W-1:0] voltage_strobe_delay
);
  logic       acc_q;
  logic       wr_q;
  logic [9:0] a_q;
  logic [1:0] lk_q;
  logic       rd_lk;
  logic       rd_st;
  assign rd_lk = acc_q && !wr_q && a_q == OFS_POWER_SETTING_LOCK[11:2];
  assign rd_st = acc_q && !wr_q && a_q == OFS_PERIODIC_TIMER_STATUS[11:2];
  // Mirrors the two sticky lock bits from word writes seen on the bus.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 1'b0;
      wr_q  <= 1'b0;
      a_q   <= 10'h0;
      lk_q  <= 2'h0;
    end else begin
      acc_q <= hsel && htrans[1] && hready;
      wr_q  <= hsel && htrans[1] && hready && hwrite;
      a_q   <= haddr[11:2];
      if (wr_q && a_q == OFS_POWER_SETTING_LOCK[11:2]) begin
        lk_q <= lk_q | hwdata[17:16];
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_wake_lock; lk_q[1] && $past(lk_q[1], 2) |-> $stable(wake_mask); endproperty
  a_wake_lock: assert property (p_wake_lock) else $error("wake mask moved");
  property p_wait_lock; lk_q[0] && $past(lk_q[0], 2) |-> $stable(voltage_strobe_delay); endproperty
  a_wait_lock: assert property (p_wait_lock) else $error("strobe delay moved");
  property p_lock_rd; rd_lk |=> hrdata == {14'h0, $past(lk_q), 16'h0}; endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("lock read wrong");
  property p_stat_rd; rd_st |=> hrdata[31:1] == 31'h0; endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");
  property p_rd_wait; acc_q && !wr_q |-> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_fast; wr_q |-> hreadyout; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_rd_hold; !(acc_q && !wr_q) |=> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_okay; hresp == HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  cover property (lk_q == 2'h3);
  cover property ($rose(irq));
  cover property (rd_st);
endmodule : aopt_sva
`default_nettype wire

// *** verif/aopt_tb.sv ***
// Self-checking bench for the always-on counter and periodic timer.
`timescale 1ns/1ps
`default_nettype none
module aopt_tb
  import aopt_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [31:0] wake_mask;
  logic [7:0]  strobe_delay;
  logic [31:0] v;
  logic [31:0] w;
  int          errors;
  int          checked;
  int          cycles;

  aopt_timer dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .wake_mask(wake_mask),
    .voltage_strobe_delay(strobe_delay)
  );

  task automatic end_sim;
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    v = hrdata;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic wirq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 40) begin
      @(posedge hclk);
      n++;
    end
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : wirq

  task automatic t_reset;
    logic [11:0] ra [6] = '{OFS_PERIODIC_TIMER_STATUS, OFS_PERIODIC_TIMER_VALUE,
      OFS_PERIODIC_TIMER_CONTROL, OFS_FREE_COUNTER_ENABLE, OFS_POWER_SETTING_LOCK,
      OFS_PERIODIC_TIMEOUT_CONFIG};
    logic [31:0] re [6] = '{32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk("reset value", re[i], v);
    end
  endtask : t_reset

  task automatic t_free;
    wr(OFS_FREE_COUNTER_ENABLE, 32'h0);
    rd(OFS_FREE_COUNTER_VALUE);
    w = v;
    wr(OFS_FREE_COUNTER_VALUE, 32'hFFFF_0000);
    rd(OFS_FREE_COUNTER_VALUE);
    chk("stopped count", w, v);
    wr(OFS_FREE_COUNTER_ENABLE, 32'h1);
    rd(OFS_FREE_COUNTER_VALUE);
    w = v;
    rd(OFS_FREE_COUNTER_VALUE);
    chk("count step", w + 32'h3, v);
  endtask : t_free

  task automatic t_period;
    wr(OFS_EVENT_MASK, 32'h1);
    wr(OFS_PERIODIC_TIMER_CONTROL, 32'h1);
    rd(OFS_PERIODIC_TIMER_STATUS);
    chk("flag clear", 32'h0, v);
    wr(OFS_PERIODIC_TIMEOUT_CONFIG, 32'h14);
    rd(OFS_PERIODIC_TIMER_VALUE);
    w = v;
    rd(OFS_PERIODIC_TIMER_VALUE);
    chk("down step", w - 32'h3, v);
    wirq(1'b1);
    rd(OFS_PERIODIC_TIMER_STATUS);
    chk("flag set", 32'h1, v);
    wr(OFS_EVENT_STATUS, 32'h1);
    repeat (50) @(posedge hclk);
    rd(OFS_EVENT_STATUS);
    chk("no new alarm", 32'h0, v);
    wirq(1'b0);
    wr(OFS_PERIODIC_TIMER_CONTROL, 32'h1);
    rd(OFS_PERIODIC_TIMER_CONTROL);
    chk("control", 32'h0, v);
    wirq(1'b1);
    wr(OFS_EVENT_MASK, 32'h0);
    wirq(1'b0);
    wr(OFS_PERIODIC_TIMEOUT_CONFIG, 32'h3E8);
    repeat (150) @(posedge hclk);
    wr(OFS_PERIODIC_TIMER_CONTROL, 32'h2);
    rd(OFS_PERIODIC_TIMER_VALUE);
    chk("reload", 32'h3E8, v);
    wr(OFS_PERIODIC_TIMEOUT_CONFIG, 32'h0);
    repeat (2) @(posedge hclk);
    rd(OFS_PERIODIC_TIMER_VALUE);
    chk("held", 32'h0, v);
  endtask : t_period

  task automatic t_lock;
    wr(OFS_WAKE_MASK, 32'hA5A5_A5A5);
    wr(OFS_POWER_SETTING_LOCK, 32'h0002_0000);
    wr(OFS_WAKE_MASK, 32'h1234_5678);
    wr(OFS_POWER_WAIT_CONFIG, 32'h11);
    wr(OFS_POWER_SETTING_LOCK, 32'h0);
    wr(OFS_POWER_SETTING_LOCK, 32'hFFFF_FFFF);
    wr(OFS_POWER_WAIT_CONFIG, 32'h22);
    rd(OFS_POWER_SETTING_LOCK);
    chk("lock", 32'h0003_0000, v);
    chk("wake mask", 32'hA5A5_A5A5, wake_mask);
    chk("strobe delay", 32'h11, {24'h0, strobe_delay});
    rd(12'h7F0);
    chk("unmapped", 32'h0, v);
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_POWER_SETTING_LOCK);
    chk("lock reset", 32'h0, v);
    chk("wake mask reset", 32'h0, wake_mask);
    chk("strobe delay reset", 32'h0, {24'h0, strobe_delay});
  endtask : t_lock

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    errors = 0;
    checked = 0;
    cycles = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_free();
    t_period();
    t_lock();
    end_sim();
  end
endmodule : aopt_tb

bind aopt_timer aopt_sva #(.WAKE_W(WAKE_W), .WAIT_W(WAIT_W)) sva_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .wake_mask(wake_mask),
  .voltage_strobe_delay(voltage_strobe_delay)
);
`default_nettype wire
